// File: pkg/scb_pkg.sv
// Constants and types shared by the system clock and boot mode block
package scb_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_CANSEL    = 8'h04;
  localparam logic [7:0]  OFF_FREEZE    = 8'h08;
  localparam logic [7:0]  OFF_MODE      = 8'h0C;
  localparam logic [7:0]  OFF_STATUS    = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SRC_LSB  = 0;
  localparam int CTRL_CME      = 2;
  localparam int CTRL_SCME     = 3;
  localparam int CTRL_QC_GO    = 4;
  localparam int CTRL_W        = 4;
  localparam int MODE_BIT      = 0;
  localparam int ST_SELF_CLK   = 0;
  localparam int ST_QC_BUSY    = 1;
  localparam int ST_QC_PASS    = 2;
  localparam int ST_QC_DONE    = 3;
  localparam int ST_SECURED    = 4;
  localparam int ST_PLL_LOCK   = 5;
  localparam int ST_SRC_LSB    = 6;
  localparam int IRQ_CM        = 0;
  localparam int IRQ_QC_PASS   = 1;
  localparam int IRQ_QC_FAIL   = 2;
  localparam int IRQ_W         = 3;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_RST      = 4'hC;
  localparam logic       MODE_NORMAL   = 1'b1;
  localparam logic       MODE_SPECIAL  = 1'b0;
  localparam logic       MODE_RST      = MODE_NORMAL;

  typedef enum logic [1:0] {
    SRC_OSC  = 2'b00,
    SRC_PLL  = 2'b01,
    SRC_SELF = 2'b10
  } scb_src_t;

  typedef enum logic [1:0] {
    QC_IDLE = 2'b00,
    QC_RUN  = 2'b01
  } scb_qc_st_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 100;
  localparam int CM_TIMEOUT_NS = 2000;
  localparam int CM_TIMEOUT_CYC = (CM_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int QC_WIN_NS     = 100000;
  localparam int QC_WIN_CYC    = QC_WIN_NS / CLK_NS;
  localparam int QC_EDGES      = 64;
  localparam int NVM_DIV       = 8;
  localparam int CNT_W         = 16;

endpackage : scb_pkg

// File: rtl/scb_qchk.sv
// Clock quality checker: counts oscillator edges inside a time window
`timescale 1ns/1ns
`default_nettype none
module scb_qchk #(
  parameter int WIN_CYC = scb_pkg::QC_WIN_CYC,
  parameter int EDGES   = scb_pkg::QC_EDGES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // Control
  input  wire logic start,
  input  wire logic osc_tick,
  // Result
  output logic      busy,
  output logic      done,
  output logic      pass
);
  import scb_pkg::*;

  typedef struct packed {
    scb_qc_st_t       st;
    logic [CNT_W-1:0] win;
    logic [CNT_W-1:0] edges;
    logic             done;
    logic             pass;
  } scb_qc_state_t;

  scb_qc_state_t r, n;

  always_comb begin
    n      = r;
    n.done = 1'b0;
    case (r.st)
      QC_IDLE: begin
        if (start) begin
          n.st    = QC_RUN;
          n.win   = '0;
          n.edges = '0;
        end
      end
      QC_RUN: begin
        n.win = r.win + 1'b1;
        if (osc_tick) begin
          n.edges = r.edges + 1'b1;
        end
        // Fixed edge count within the window means the clock runs
        if (osc_tick && (r.edges == CNT_W'(EDGES - 1))) begin
          n.st   = QC_IDLE;
          n.done = 1'b1;
          n.pass = 1'b1;
        end else if (r.win == CNT_W'(WIN_CYC - 1)) begin
          n.st   = QC_IDLE;
          n.done = 1'b1;
          n.pass = 1'b0;
        end
      end
      default: begin
        n.st = QC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r <= '{st: QC_IDLE, win: '0, edges: '0, done: 1'b0, pass: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign busy = (r.st == QC_RUN);
  assign done = r.done;
  assign pass = r.pass;

endmodule : scb_qchk
`default_nettype wire

// File: rtl/scb_top.sv
// System clock distribution, clock monitor and boot mode capture
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module scb_top #(
  parameter int N_CAN   = 2,
  parameter int N_FRZ   = 3,
  parameter int NVM_DV  = scb_pkg::NVM_DIV,
  parameter int CM_CYC  = scb_pkg::CM_TIMEOUT_CYC,
  parameter int QC_WIN  = scb_pkg::QC_WIN_CYC,
  parameter int QC_EDG  = scb_pkg::QC_EDGES
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       srst,
  // Register port
  input  wire logic [scb_pkg::ADDR_W-1:0] addr,
  input  wire logic [scb_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [scb_pkg::DATA_W-1:0] rd_data,
  // Pins and on-chip status
  input  wire logic                       osc_pin,
  input  wire logic                       reset_pin_n,
  input  wire logic                       boot_mode_select,
  input  wire logic                       pll_lock,
  input  wire logic                       secured,
  input  wire logic                       bdu_busy,
  input  wire logic                       wake_evt,
  // Clock source and enables
  output logic      [1:0]                 sys_src,
  output logic                            core_clk_en,
  output logic                            bus_clk_en,
  output logic                            lcd_clk_en,
  output logic                            flash_bus_en,
  output logic                            flash_osc_en,
  output logic                            nvm_tb_en,
  output logic      [N_CAN-1:0]           can_clk_en,
  // System control
  output logic                            cm_reset_req,
  output logic      [N_FRZ-1:0]           freeze,
  output logic                            normal_mode,
  output logic                            debug_en,
  output logic                            fetch_reset_vector,
  output logic                            bdu_enable,
  output logic                            monitor_run,
  output logic                            irq
);
  import scb_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                osc_s1, osc_s2, osc_d;
    logic                rstp_s1, rstp_s2, rstp_d;
    logic                strap_s1, strap_s2;
    logic                lock_s1, lock_s2;
    logic                sec_s1, sec_s2;
    logic [CTRL_W-1:0]   ctrl;
    logic [N_CAN-1:0]    can_sel;
    logic [N_FRZ-1:0]    frz_en;
    logic                mode;
    logic                self_clk;
    logic                cm_fail;
    logic [CNT_W-1:0]    cm_cnt;
    logic [CNT_W-1:0]    nvm_cnt;
    logic                bus_ph;
    logic [IRQ_W-1:0]    irq_st;
    logic [IRQ_W-1:0]    irq_mask;
    logic [DATA_W-1:0]   rd_data;
    logic [1:0]          src;
    logic                core_en, bus_en, lcd_en, fl_bus, fl_osc, nvm_en;
    logic [N_CAN-1:0]    can_en;
    logic                cm_rst;
    logic [N_FRZ-1:0]    frz;
    logic                dbg_en;
    logic                irq;
  } scb_state_t;

  scb_state_t r, n;

  logic osc_tick;
  logic sys_tick;
  logic qc_start;
  logic qc_busy;
  logic qc_done;
  logic qc_pass;
  logic cm_event;
  logic can_pick [N_CAN];

  // ----------------------------------------------------------------
  // Oscillator edge and clock source
  // ----------------------------------------------------------------
  assign osc_tick = r.osc_s2 & ~r.osc_d;
  // Oscillator source only ticks on osc edges; PLL and self-clock sources run every cycle
  assign sys_tick = (r.src == SRC_OSC) ? osc_tick : 1'b1;

  // Monitor fires once per failure, counted from the last oscillator edge
  assign cm_event = ~osc_tick & ~r.cm_fail & r.ctrl[CTRL_CME]
                    & (r.cm_cnt == CNT_W'(CM_CYC - 1));

  // Software start, wake-up and monitor failure all launch a check
  assign qc_start = cm_event | wake_evt
                    | (wr_en & (addr == OFF_CTRL) & wr_data[CTRL_QC_GO]);

  // ----------------------------------------------------------------
  // Per-channel CAN clock choice
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N_CAN; gi++) begin : g_can
      assign can_pick[gi] = r.can_sel[gi] ? osc_tick : (sys_tick & r.bus_ph);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Quality checker
  // ----------------------------------------------------------------
  scb_qchk #(
    .WIN_CYC (QC_WIN),
    .EDGES   (QC_EDG)
  ) u_qchk (
    .clock    (clock),
    .srst     (srst),
    .start    (qc_start),
    .osc_tick (osc_tick),
    .busy     (qc_busy),
    .done     (qc_done),
    .pass     (qc_pass)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;

    // Two-stage sync for every pin; logic reads stage two and, for osc and reset, its one-cycle delay
    n.osc_s1   = osc_pin;
    n.osc_s2   = r.osc_s1;
    n.osc_d    = r.osc_s2;
    n.rstp_s1  = reset_pin_n;
    n.rstp_s2  = r.rstp_s1;
    n.rstp_d   = r.rstp_s2;
    n.strap_s1 = boot_mode_select;
    n.strap_s2 = r.strap_s1;
    n.lock_s1  = pll_lock;
    n.lock_s2  = r.lock_s1;
    n.sec_s1   = secured;
    n.sec_s2   = r.sec_s1;

    // Clock monitor counter restarts on each oscillator edge
    if (osc_tick) begin
      n.cm_cnt = '0;
    end else if (r.cm_cnt != CNT_W'(CM_CYC - 1)) begin
      n.cm_cnt = r.cm_cnt + 1'b1;
    end

    n.cm_rst = 1'b0;
    if (cm_event) begin
      n.cm_fail = 1'b1;
      if (r.ctrl[CTRL_SCME]) begin
        n.self_clk = 1'b1;
      end else begin
        n.cm_rst = 1'b1;
      end
    end
    // A passing check proves the oscillator back and leaves self-clock
    if (qc_done && qc_pass) begin
      n.self_clk = 1'b0;
      n.cm_fail  = 1'b0;
    end

    // Source: forced self-clock wins; PLL only once it has locked
    if (n.self_clk) begin
      n.src = SRC_SELF;
    end else if (r.ctrl[CTRL_SRC_LSB +: 2] == SRC_SELF) begin
      n.src = SRC_SELF;
    end else if (r.ctrl[CTRL_SRC_LSB +: 2] == SRC_PLL && r.lock_s2) begin
      n.src = SRC_PLL;
    end else begin
      n.src = SRC_OSC;
    end

    // Core and bus enables; bus runs at half the core rate
    n.core_en = sys_tick;
    if (sys_tick) begin
      n.bus_ph = ~r.bus_ph;
    end
    n.bus_en = sys_tick & r.bus_ph;

    // Display clock has no selector on purpose
    n.lcd_en = osc_tick;

    // Flash sees both bus and oscillator; NVM timebase divides osc
    n.fl_bus = sys_tick & r.bus_ph;
    n.fl_osc = osc_tick;
    n.nvm_en = 1'b0;
    if (osc_tick) begin
      if (r.nvm_cnt == CNT_W'(NVM_DV - 1)) begin
        n.nvm_cnt = '0;
        n.nvm_en  = 1'b1;
      end else begin
        n.nvm_cnt = r.nvm_cnt + 1'b1;
      end
    end

    for (int i = 0; i < N_CAN; i++) begin
      n.can_en[i] = can_pick[i];
    end

    // Freeze only while the debug unit is actually active
    n.frz = r.frz_en & {N_FRZ{bdu_busy}};

    // Boot strap captured on the rising edge of the reset pin
    if (r.rstp_s2 && !r.rstp_d) begin
      n.mode = r.strap_s2;
    end

    // Register writes
    if (wr_en) begin
      case (addr)
        OFF_CTRL: begin
          n.ctrl = wr_data[CTRL_W-1:0];
        end
        OFF_CANSEL: begin
          n.can_sel = wr_data[N_CAN-1:0];
        end
        OFF_FREEZE: begin
          n.frz_en = wr_data[N_FRZ-1:0];
        end
        OFF_MODE: begin
          // Leaving special mode is allowed; entering it is not
          if (r.mode == MODE_SPECIAL && wr_data[MODE_BIT] == MODE_NORMAL) begin
            n.mode = MODE_NORMAL;
          end
        end
        OFF_IRQ_STAT: begin
          n.irq_st = r.irq_st & ~wr_data[IRQ_W-1:0];
        end
        OFF_IRQ_MASK: begin
          n.irq_mask = wr_data[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Events set after the clear so a same-cycle event is kept
    if (cm_event) begin
      n.irq_st[IRQ_CM] = 1'b1;
    end
    if (qc_done && qc_pass) begin
      n.irq_st[IRQ_QC_PASS] = 1'b1;
    end
    if (qc_done && !qc_pass) begin
      n.irq_st[IRQ_QC_FAIL] = 1'b1;
    end
    n.irq = |(n.irq_st & n.irq_mask);

    // Debug is open when unsecured, or in special mode
    n.dbg_en = ~r.sec_s2 | (r.mode == MODE_SPECIAL);

    // Register reads, data valid in the following cycle only
    n.rd_data = '0;
    if (rd_en) begin
      case (addr)
        OFF_CTRL:     n.rd_data[CTRL_W-1:0] = r.ctrl;
        OFF_CANSEL:   n.rd_data[N_CAN-1:0]  = r.can_sel;
        OFF_FREEZE:   n.rd_data[N_FRZ-1:0]  = r.frz_en;
        OFF_MODE:     n.rd_data[MODE_BIT]   = r.mode;
        OFF_STATUS: begin
          n.rd_data[ST_SELF_CLK]      = r.self_clk;
          n.rd_data[ST_QC_BUSY]       = qc_busy;
          n.rd_data[ST_QC_PASS]       = qc_pass;
          n.rd_data[ST_QC_DONE]       = r.irq_st[IRQ_QC_PASS] | r.irq_st[IRQ_QC_FAIL];
          n.rd_data[ST_SECURED]       = r.sec_s2;
          n.rd_data[ST_PLL_LOCK]      = r.lock_s2;
          n.rd_data[ST_SRC_LSB +: 2]  = r.src;
        end
        OFF_IRQ_STAT: n.rd_data[IRQ_W-1:0]  = r.irq_st;
        OFF_IRQ_MASK: n.rd_data[IRQ_W-1:0]  = r.irq_mask;
        default:      n.rd_data             = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      r          <= '0;
      r.rstp_s1  <= 1'b1;
      r.rstp_s2  <= 1'b1;
      r.rstp_d   <= 1'b1;
      r.ctrl     <= CTRL_RST;
      r.mode     <= MODE_RST;
      r.src      <= SRC_OSC;
      r.dbg_en   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data            = r.rd_data;
  assign sys_src            = r.src;
  assign core_clk_en        = r.core_en;
  assign bus_clk_en         = r.bus_en;
  assign lcd_clk_en         = r.lcd_en;
  assign flash_bus_en       = r.fl_bus;
  assign flash_osc_en       = r.fl_osc;
  assign nvm_tb_en          = r.nvm_en;
  assign can_clk_en         = r.can_en;
  assign cm_reset_req       = r.cm_rst;
  assign freeze             = r.frz;
  assign normal_mode        = r.mode;
  assign debug_en           = r.dbg_en;
  assign fetch_reset_vector = (r.mode == MODE_NORMAL);
  assign bdu_enable         = (r.mode == MODE_SPECIAL);
  assign monitor_run        = (r.mode == MODE_SPECIAL);
  assign irq                = r.irq;

endmodule : scb_top
`default_nettype wire

// File: sim/scb_board_model.sv
// Board side: oscillator, reset pin and boot strap
`timescale 1ns/1ns
`default_nettype none
module scb_board_model (
  // Clock
  input wire logic       clock,
  // Bench control
  input wire logic       osc_run,
  input wire logic [3:0] osc_half,
  input wire logic       pin_rst_req,
  input wire logic       strap_lvl,
  // Pins
  output var logic       osc_pin,
  output wire logic      reset_pin_n,
  output wire logic      boot_mode_select
);
  logic [3:0] ph_r = 4'h0;
  logic [2:0] rst_cnt_r = 3'h0;
  initial osc_pin = 1'b0;
  always @(posedge clock) begin
    // A stopped crystal holds its last level
    if (osc_run && ph_r + 4'h1 >= osc_half) begin
      osc_pin <= ~osc_pin;
      ph_r    <= 4'h0;
    end else if (osc_run) begin
      ph_r <= ph_r + 4'h1;
    end
    if (pin_rst_req)
      rst_cnt_r <= 3'h4;
    else if (rst_cnt_r != 3'h0)
      rst_cnt_r <= rst_cnt_r - 3'h1;
  end
  assign reset_pin_n      = (rst_cnt_r == 3'h0);
  assign boot_mode_select = strap_lvl;
endmodule : scb_board_model
`default_nettype wire

// File: sim/scb_properties.sv
// Port-level checks for the system clock and boot mode block
`timescale 1ns/1ns
`default_nettype none
module scb_properties #(
  parameter int N_FRZ  = 3,
  parameter int CM_CYC = 16
) (
  // Clock and reset
  input wire logic             clock,
  input wire logic             srst,
  // Watched ports
  input wire logic             reset_pin_n,
  input wire logic             bdu_busy,
  input wire logic [1:0]       sys_src,
  input wire logic             bus_clk_en,
  input wire logic             lcd_clk_en,
  input wire logic             flash_bus_en,
  input wire logic             flash_osc_en,
  input wire logic             cm_reset_req,
  input wire logic [N_FRZ-1:0] freeze,
  input wire logic             normal_mode,
  input wire logic             debug_en,
  input wire logic             fetch_reset_vector,
  input wire logic             bdu_enable,
  input wire logic             monitor_run
);
  logic [7:0] quiet_r;
  logic [7:0] pin_age_r;
  // Saturating ages: cycles since the last display tick and since the pin was low
  always_ff @(posedge clock) begin
    if (srst || lcd_clk_en)
      quiet_r <= 8'h00;
    else if (quiet_r != 8'hFF)
      quiet_r <= quiet_r + 8'h01;
    if (srst)
      pin_age_r <= 8'hFF;
    else if (!reset_pin_n)
      pin_age_r <= 8'h00;
    else if (pin_age_r != 8'hFF)
      pin_age_r <= pin_age_r + 8'h01;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence osc_gap;
    !lcd_clk_en [*4];
  endsequence
  sequence req_drop;
    ##1 !cm_reset_req;
  endsequence
  lcd_pulse_a: assert property (lcd_clk_en |=> osc_gap)
    else $error("display tick not isolated");
  src_legal_a: assert property (sys_src != 2'b11)
    else $error("illegal system source");
  bus_half_a: assert property (bus_clk_en |=> !bus_clk_en)
    else $error("bus tick on two cycles");
  flash_mirror_a: assert property (
    flash_osc_en == lcd_clk_en && flash_bus_en == bus_clk_en)
    else $error("flash enables differ");
  cm_quiet_a: assert property (cm_reset_req |-> quiet_r >= CM_CYC - 3)
    else $error("monitor fired while oscillator ran");
  cm_pulse_a: assert property (cm_reset_req |-> req_drop)
    else $error("reset request too long");
  frz_cause_a: assert property (|freeze |-> $past(bdu_busy))
    else $error("freeze without debug activity");
  mode_fall_a: assert property ($fell(normal_mode) |-> pin_age_r <= 8'h05)
    else $error("mode changed away from pin release");
  mode_decode_a: assert property (
    fetch_reset_vector == normal_mode && bdu_enable == !normal_mode
    && monitor_run == bdu_enable)
    else $error("mode decode wrong");
  dbg_special_a: assert property ($past(normal_mode) == 1'b0 |-> debug_en)
    else $error("debug off in special mode");
endmodule : scb_properties
`default_nettype wire

// File: sim/scb_top_tb.sv
// Self-checking bench for the system clock and boot mode block
`timescale 1ns/1ns
`default_nettype none
module scb_top_tb;
  import scb_pkg::*;
  localparam int CMC  = 16;
  localparam int NVMD = 8;
  logic        clock, srst, wr_en, rd_en, pll_lock, secured, bdu_busy, wake_evt;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data, d, r;
  logic        osc_run, pin_rst_req, strap_lvl, osc_pin, reset_pin_n, boot_mode_select;
  logic [3:0]  osc_half;
  logic [1:0]  sys_src, can_clk_en;
  logic        core_clk_en, bus_clk_en, lcd_clk_en, flash_bus_en, flash_osc_en, nvm_tb_en;
  logic        cm_reset_req, normal_mode, debug_en, fetch_reset_vector, bdu_enable;
  logic        monitor_run, irq;
  logic [2:0]  freeze;
  logic [5:0]  pv;
  int          np [6];
  int          seed = 32'hFCAC5C99;
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;
  int          ne;
  scb_top #(.N_CAN(2), .N_FRZ(3), .NVM_DV(NVMD), .CM_CYC(CMC), .QC_WIN(100), .QC_EDG(4))
  u_dut (.clock, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .osc_pin, .reset_pin_n,
    .boot_mode_select, .pll_lock, .secured, .bdu_busy, .wake_evt, .sys_src, .core_clk_en,
    .bus_clk_en, .lcd_clk_en, .flash_bus_en, .flash_osc_en, .nvm_tb_en, .can_clk_en,
    .cm_reset_req, .freeze, .normal_mode, .debug_en, .fetch_reset_vector, .bdu_enable,
    .monitor_run, .irq);
  scb_board_model u_board (.clock, .osc_run, .osc_half, .pin_rst_req, .strap_lvl,
    .osc_pin, .reset_pin_n, .boot_mode_select);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Run ceiling well above the roughly 1500 cycles the sequence needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Tick counts may be one off at the window edges
  task automatic cn(input int got, input int exp);
    chk((got >= exp - 1 && got <= exp + 1) ? exp : got, exp);
  endtask : cn
  function automatic logic exp_dbg(input logic sec, input logic nrm);
    return !sec || !nrm;
  endfunction : exp_dbg
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    tick(1);
    wr_en <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    addr  <= a;
    rd_en <= 1'b1;
    tick(1);
    d = rd_data;
    rd_en <= 1'b0;
    tick(1);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask : rc
  task automatic count(input int n);
    np = '{default: 0};
    repeat (n) begin
      tick(1);
      pv = {nvm_tb_en, can_clk_en, lcd_clk_en, bus_clk_en, core_clk_en};
      foreach (np[i]) np[i] += int'(pv[i]);
    end
  endtask : count
  task automatic qc_wait();
    tick(4);
    d = 32'h2;
    for (int i = 0; i < 80 && d[ST_QC_BUSY] !== 1'b0; i++) rd(OFF_STATUS);
    // The pending bit lands one cycle after busy drops, so look once more
    rd(OFF_STATUS);
  endtask : qc_wait
  initial begin
    srst = 1'b1;
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    pll_lock = 1'b0;
    secured = 1'b0;
    bdu_busy = 1'b0;
    wake_evt = 1'b0;
    osc_run = 1'b1;
    osc_half = 4'h3;
    pin_rst_req = 1'b0;
    strap_lvl = 1'b1;
    tick(10);
    srst <= 1'b0;
    tick(1);
    rc(OFF_CTRL, {28'h0, CTRL_RST});
    rc(OFF_MODE, 32'h1);
    rc(8'h1C, 32'h0);
    chk(rd_data, 32'h0);
    secured <= 1'b1;
    tick(6);
    chk(debug_en, exp_dbg(1'b1, 1'b1));
    rd(OFF_STATUS);
    chk(d[ST_SECURED], 1'b1);
    for (int s = 1; s >= 0; s--) begin
      strap_lvl   <= s[0];
      pin_rst_req <= 1'b1;
      tick(1);
      pin_rst_req <= 1'b0;
      tick(12);
      chk(normal_mode, s[0]);
      chk({fetch_reset_vector, bdu_enable, monitor_run}, {s[0], !s[0], !s[0]});
      chk(debug_en, exp_dbg(1'b1, s[0]));
    end
    strap_lvl <= 1'b1;
    tick(8);
    chk(normal_mode, 1'b0);
    wr(OFF_MODE, 32'h0);
    rc(OFF_MODE, 32'h0);
    wr(OFF_MODE, 32'h1);
    rc(OFF_MODE, 32'h1);
    chk(fetch_reset_vector, 1'b1);
    wr(OFF_MODE, 32'h0);
    rc(OFF_MODE, 32'h1);
    secured <= 1'b0;
    // A source request is held off until the loop reports lock
    wr(OFF_CTRL, 32'hD);
    tick(6);
    chk(sys_src, SRC_OSC);
    pll_lock <= 1'b1;
    tick(4);
    wr(OFF_CTRL, 32'hD);
    tick(4);
    chk(sys_src, SRC_PLL);
    count(40);
    chk(np[0], 40);
    cn(np[1], 20);
    wr(OFF_CTRL, 32'hE);
    tick(2);
    chk(sys_src, SRC_SELF);
    wr(OFF_CTRL, 32'hC);
    for (int cs = 0; cs < 4; cs++) begin
      r = $random(seed);
      osc_half <= 4'h3 + {2'b00, r[1:0]};
      wr(OFF_CANSEL, cs);
      tick(16);
      count(240);
      ne = 240 / (2 * int'(osc_half));
      cn(np[2], ne);
      cn(np[0], ne);
      cn(np[1], ne / 2);
      cn(np[3], cs[0] ? ne : ne / 2);
      cn(np[4], cs[1] ? ne : ne / 2);
      cn(np[5], ne / NVMD);
    end
    r = $random(seed);
    wr(OFF_FREEZE, {29'h0, r[2:1], 1'b1});
    rc(OFF_FREEZE, {29'h0, r[2:1], 1'b1});
    bdu_busy <= 1'b1;
    tick(3);
    chk(freeze, {r[2:1], 1'b1});
    bdu_busy <= 1'b0;
    tick(3);
    chk(freeze, 3'h0);
    wr(OFF_IRQ_MASK, 32'h7);
    wr(OFF_CTRL, 32'h1C);
    qc_wait();
    chk(d[ST_QC_DONE:ST_QC_PASS], 2'b11);
    chk(irq, 1'b1);
    rc(OFF_IRQ_STAT, 32'h2);
    wr(OFF_IRQ_STAT, 32'h2);
    chk(irq, 1'b0);
    rc(OFF_IRQ_STAT, 32'h0);
    osc_run <= 1'b0;
    tick(30);
    qc_wait();
    chk(d[ST_QC_PASS], 1'b0);
    chk(d[ST_SELF_CLK], 1'b1);
    chk(sys_src, SRC_SELF);
    rc(OFF_IRQ_STAT, 32'h5);
    wr(OFF_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h4);
    chk(irq, 1'b1);
    wr(OFF_IRQ_STAT, 32'h7);
    chk(irq, 1'b0);
    osc_run  <= 1'b1;
    wake_evt <= 1'b1;
    tick(1);
    wake_evt <= 1'b0;
    qc_wait();
    rc(OFF_IRQ_STAT, 32'h2);
    wr(OFF_CTRL, 32'h4);
    osc_run <= 1'b0;
    r = 32'h0;
    repeat (60) begin
      tick(1);
      r[0] = r[0] | cm_reset_req;
    end
    chk(r[0], 1'b1);
    complete_run();
  end
endmodule : scb_top_tb
bind scb_top scb_properties #(.N_FRZ(N_FRZ), .CM_CYC(CM_CYC)) u_props (.clock, .srst,
  .reset_pin_n, .bdu_busy, .sys_src, .bus_clk_en, .lcd_clk_en, .flash_bus_en,
  .flash_osc_en, .cm_reset_req, .freeze, .normal_mode, .debug_en, .fetch_reset_vector,
  .bdu_enable, .monitor_run);
`default_nettype wire
